// *** aec_pkg.sv ***
// package for the automatic exposure control block: register map, field layouts and constants
package aec_pkg;

  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_TARGET = 8'h04;
  localparam logic [7:0] OFF_EXP_LIM = 8'h08;
  localparam logic [7:0] OFF_GAIN_LIM = 8'h0c;
  localparam logic [7:0] OFF_TGT_LIM = 8'h10;
  localparam logic [7:0] OFF_REGION_OFS = 8'h14;
  localparam logic [7:0] OFF_REGION_SIZE = 8'h18;
  localparam logic [7:0] OFF_STATUS = 8'h1c;
  localparam logic [7:0] OFF_EXP_FIX = 8'h20;

  // control field positions
  localparam int CTRL_EXP_AUTO_LSB = 0;
  localparam int CTRL_GAIN_AUTO_LSB = 2;
  localparam int CTRL_TGT_AUTO_BIT = 4;
  localparam int CTRL_PRIO_BIT = 5;
  localparam int CTRL_LIGHT_LSB = 6;
  localparam int CTRL_METER_LSB = 8;
  localparam int CTRL_OWNER_BIT = 10;
  localparam int CTRL_REGION_USE_BIT = 11;
  localparam int CTRL_DAMP_LSB = 12;
  localparam int CTRL_BIAS_LSB = 16;

  // auto setting, lighting and metering encodings
  typedef enum logic [1:0] {AUTO_OFF = 2'b00, AUTO_ONCE = 2'b01, AUTO_CONT = 2'b10} aec_auto_e;
  typedef enum logic [1:0] {LIGHT_NORMAL = 2'b00, LIGHT_BACK = 2'b01, LIGHT_FRONT = 2'b10} aec_light_e;
  typedef enum logic [1:0] {METER_AVG = 2'b00, METER_SPOT = 2'b01, METER_PART = 2'b10} aec_meter_e;
  typedef enum logic [1:0] {ST_IDLE = 2'b00, ST_ACC = 2'b01, ST_ADJ = 2'b10} aec_state_e;

  // reset values; exposure in us, gain in 0.1 dB, target in percent
  localparam logic [15:0] EXP_MIN_RST = 16'h000a;
  localparam logic [15:0] EXP_MAX_RST = 16'hffff;
  localparam logic [15:0] EXP_FIX_RST = 16'h1388; // 5 ms small exposure
  localparam logic [15:0] GAIN_MIN_RST = 16'h0000;
  localparam logic [15:0] GAIN_MAX_RST = 16'h01b8;
  localparam logic [7:0] TGT_RST = 8'h32;
  localparam logic [7:0] TGT_MIN_RST = 8'h00;
  localparam logic [7:0] TGT_MAX_RST = 8'h64;
  localparam logic [3:0] DAMP_RST = 4'h8; // 8/16 = 0.5
  localparam logic [7:0] PCT_FULL = 8'h64;
  localparam logic [7:0] TOL_PCT = 8'h01; // settled band around the target
  localparam logic [7:0] LIGHT_SHIFT = 8'h0a; // target shift for light modes

  // sensor settings carried out as one group
  typedef struct packed {
    logic [15:0] exposure_us;
    logic [15:0] gain_ddb;
  } aec_sensor_s;

  // one pixel on the statistics stream
  typedef struct packed {
    logic valid;
    logic sof;
    logic eof;
    logic [15:0] x;
    logic [15:0] y;
    logic [7:0] luma;
  } aec_pix_s;

endpackage : aec_pkg

// *** aec_ctrl.sv ***
// automatic exposure control loop with its apb register file
`timescale 1ns/1ps

// What this block does
// - acts only when exposure or gain auto
// - steers measured average toward the target
// - continuous target uses user brightness percent
// - target off derives target from modes
// - exposure kept between programmable microsecond bounds
// - gain kept between programmable decibel bounds
// - target clamped between percent bounds
// - damping 0 to 15/16 in sixteenths sets settle speed
// - priority picks which setting moves first
// - gain priority: gain 0, exposure first
// - exposure priority: fixed small exposure, gain first
// - lighting backlight, frontlight, normal; normal default
// - backlight avoids underexposing the subject
// - frontlight avoids overexposing the subject
// - metering average, spot, partial; needs normal
// - average metering weighs all pixels equally
// - spot metering uses centre three percent
// - partial metering uses centre eleven percent
// - measurement region within the captured region
// - host enables region then sets its rectangle
// - brightness bias -3..3 in thirds
module aec_ctrl #(
  parameter int IMG_W = 640,
  parameter int IMG_H = 480
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire aec_pkg::aec_pix_s pix_i,
  output aec_pkg::aec_sensor_s sensor_o,
  output logic sensor_upd_o
);
  import aec_pkg::*;

  typedef struct packed {
    aec_auto_e exp_auto;
    aec_auto_e gain_auto;
    logic tgt_cont;
    logic prio_exp;
    aec_light_e light;
    aec_meter_e meter;
    logic owner_ae;
    logic region_use;
    logic [3:0] damp;
    logic signed [4:0] bias;
    logic [7:0] target;
    logic [15:0] exp_min;
    logic [15:0] exp_max;
    logic [15:0] gain_min;
    logic [15:0] gain_max;
    logic [15:0] exp_fix;
    logic [7:0] tgt_min;
    logic [7:0] tgt_max;
    logic [15:0] reg_x;
    logic [15:0] reg_y;
    logic [15:0] reg_w;
    logic [15:0] reg_h;
    aec_state_e state;
    logic [39:0] sum;
    logic [23:0] cnt;
    logic [7:0] meas;
    logic settled;
    logic armed;
    aec_sensor_s sensor;
    logic upd;
    logic [31:0] rdata;
  } aec_state_s;

  aec_state_s q;
  aec_state_s next_q;

  // unsigned fraction of a value; used for damping steps
  function automatic logic [15:0] damp_step(input logic [15:0] v, input logic [3:0] d);
    logic [19:0] p;
    p = 20'(v) * 20'(5'd16 - 5'(d));
    damp_step = p[19:4];
  endfunction : damp_step

  // clamp helper for 16-bit settings
  function automatic logic [15:0] clamp16(input logic [16:0] v, input logic [15:0] lo, input logic [15:0] hi);
    if (v < 17'(lo)) begin
      clamp16 = lo;
    end else if (v > 17'(hi)) begin
      clamp16 = hi;
    end else begin
      clamp16 = v[15:0];
    end
  endfunction : clamp16

  // centred window test: half extents are scaled from the frame size
  function automatic logic in_centre(input logic [15:0] x, input logic [15:0] y, input int num);
    int hw;
    int hh;
    int cx;
    int cy;
    hw = (IMG_W * num) / 200;
    hh = (IMG_H * num) / 200;
    cx = IMG_W / 2;
    cy = IMG_H / 2;
    in_centre = (int'(x) >= cx - hw) && (int'(x) < cx + hw) && (int'(y) >= cy - hh) && (int'(y) < cy + hh);
  endfunction : in_centre

  logic wr;
  logic rd;
  logic active;
  logic in_meter;
  logic in_region;
  logic [7:0] wgt;
  logic [8:0] tgt_raw;
  logic [8:0] tgt_biased;
  logic [7:0] tgt;
  logic [7:0] err;
  logic bright;
  logic [15:0] e_step;
  logic [15:0] g_step;
  logic [16:0] e_new;
  logic [16:0] g_new;
  logic e_auto;
  logic g_auto;

  // apb answers in the access cycle, no wait states
  assign pready_o = 1'b1;
  assign pslverr_o = 1'b0;
  assign prdata_o = q.rdata;
  assign sensor_o = q.sensor;
  assign sensor_upd_o = q.upd;
  assign wr = psel_i & penable_i & pwrite_i;
  assign rd = psel_i & ~penable_i & ~pwrite_i;

  assign e_auto = (q.exp_auto != AUTO_OFF);
  assign g_auto = (q.gain_auto != AUTO_OFF);
  assign active = e_auto | g_auto;

  // metering window; light modes meter the whole region
  always_comb begin
    in_meter = 1'b1;
    if (q.light == LIGHT_NORMAL) begin
      unique case (q.meter)
        METER_SPOT: in_meter = in_centre(pix_i.x, pix_i.y, 17); // 17% per side ~ 3% area
        METER_PART: in_meter = in_centre(pix_i.x, pix_i.y, 33); // 33% per side ~ 11% area
        default: in_meter = 1'b1;
      endcase
    end
    // rectangle only when owned by exposure and enabled
    in_region = 1'b1;
    if (q.owner_ae && q.region_use) begin
      in_region = (pix_i.x >= q.reg_x) && (17'(pix_i.x) < 17'(q.reg_x) + 17'(q.reg_w)) &&
                  (pix_i.y >= q.reg_y) && (17'(pix_i.y) < 17'(q.reg_y) + 17'(q.reg_h));
    end
    // backlight counts dark pixels double, frontlight bright ones
    wgt = 8'h01;
    if (q.light == LIGHT_BACK && pix_i.luma < 8'h80) begin
      wgt = 8'h02;
    end else if (q.light == LIGHT_FRONT && pix_i.luma >= 8'h80) begin
      wgt = 8'h02;
    end
  end

  // target choice, bias and clamp
  always_comb begin
    if (q.tgt_cont) begin
      tgt_raw = 9'(q.target);
    end else begin
      unique case (q.light)
        LIGHT_BACK: tgt_raw = 9'(TGT_RST) + 9'(LIGHT_SHIFT);
        LIGHT_FRONT: tgt_raw = 9'(TGT_RST) - 9'(LIGHT_SHIFT);
        default: tgt_raw = 9'(TGT_RST);
      endcase
    end
    // one third stop taken as about 4 percent of full scale
    tgt_biased = 9'(signed'(10'(tgt_raw)) + 10'(q.bias) * 10'sd4);
    if (tgt_biased[8]) begin
      tgt = 8'h00;
    end else if (tgt_biased[7:0] > PCT_FULL) begin
      tgt = PCT_FULL;
    end else begin
      tgt = tgt_biased[7:0];
    end
    if (tgt < q.tgt_min) begin
      tgt = q.tgt_min;
    end else if (tgt > q.tgt_max) begin
      tgt = q.tgt_max;
    end
    bright = q.meas > tgt;
    err = bright ? q.meas - tgt : tgt - q.meas;
  end

  // main next-state process
  always_comb begin
    next_q = q;
    next_q.upd = 1'b0;
    e_step = 16'h0000;
    g_step = 16'h0000;
    e_new = 17'(q.sensor.exposure_us);
    g_new = 17'(q.sensor.gain_ddb);
    // register writes
    if (wr) begin
      unique case (paddr_i)
        OFF_CTRL: begin
          next_q.exp_auto = aec_auto_e'(pwdata_i[CTRL_EXP_AUTO_LSB +: 2]);
          next_q.gain_auto = aec_auto_e'(pwdata_i[CTRL_GAIN_AUTO_LSB +: 2]);
          next_q.tgt_cont = pwdata_i[CTRL_TGT_AUTO_BIT];
          next_q.prio_exp = pwdata_i[CTRL_PRIO_BIT];
          next_q.light = aec_light_e'(pwdata_i[CTRL_LIGHT_LSB +: 2]);
          if (aec_light_e'(pwdata_i[CTRL_LIGHT_LSB +: 2]) == LIGHT_NORMAL) begin
            next_q.meter = aec_meter_e'(pwdata_i[CTRL_METER_LSB +: 2]);
          end
          next_q.owner_ae = pwdata_i[CTRL_OWNER_BIT];
          next_q.region_use = pwdata_i[CTRL_REGION_USE_BIT];
          next_q.damp = pwdata_i[CTRL_DAMP_LSB +: 4];
          if ($signed(pwdata_i[CTRL_BIAS_LSB +: 5]) >= -5'sd9 && $signed(pwdata_i[CTRL_BIAS_LSB +: 5]) <= 5'sd9) begin
            next_q.bias = pwdata_i[CTRL_BIAS_LSB +: 5];
          end
        end
        OFF_TARGET: next_q.target = (pwdata_i[7:0] > PCT_FULL) ? PCT_FULL : pwdata_i[7:0];
        OFF_EXP_LIM: begin
          next_q.exp_min = pwdata_i[15:0];
          next_q.exp_max = pwdata_i[31:16];
        end
        OFF_GAIN_LIM: begin
          next_q.gain_min = pwdata_i[15:0];
          next_q.gain_max = pwdata_i[31:16];
        end
        OFF_TGT_LIM: begin
          next_q.tgt_min = pwdata_i[7:0];
          next_q.tgt_max = pwdata_i[15:8];
        end
        OFF_REGION_OFS: begin
          // region must stay inside the captured frame
          next_q.reg_x = (32'(pwdata_i[15:0]) < IMG_W) ? pwdata_i[15:0] : 16'h0000;
          next_q.reg_y = (32'(pwdata_i[31:16]) < IMG_H) ? pwdata_i[31:16] : 16'h0000;
        end
        OFF_REGION_SIZE: begin
          next_q.reg_w = (32'(q.reg_x) + 32'(pwdata_i[15:0]) <= IMG_W) ? pwdata_i[15:0] : 16'(IMG_W - int'(q.reg_x));
          next_q.reg_h = (32'(q.reg_y) + 32'(pwdata_i[31:16]) <= IMG_H) ? pwdata_i[31:16] : 16'(IMG_H - int'(q.reg_y));
        end
        OFF_EXP_FIX: next_q.exp_fix = pwdata_i[15:0];
        default: ;
      endcase
    end
    // register reads, captured in setup so data is ready in access
    next_q.rdata = 32'h0000_0000;
    if (rd) begin
      unique case (paddr_i)
        OFF_CTRL: next_q.rdata = {11'h000, q.bias, q.damp, q.region_use, q.owner_ae, q.meter, q.light,
                                   q.prio_exp, q.tgt_cont, q.gain_auto, q.exp_auto};
        OFF_TARGET: next_q.rdata = {24'h000000, q.target};
        OFF_EXP_LIM: next_q.rdata = {q.exp_max, q.exp_min};
        OFF_GAIN_LIM: next_q.rdata = {q.gain_max, q.gain_min};
        OFF_TGT_LIM: next_q.rdata = {16'h0000, q.tgt_max, q.tgt_min};
        OFF_REGION_OFS: next_q.rdata = {q.reg_y, q.reg_x};
        OFF_REGION_SIZE: next_q.rdata = {q.reg_h, q.reg_w};
        OFF_STATUS: next_q.rdata = {7'h00, q.settled, tgt, q.meas, 6'h00, q.state};
        OFF_EXP_FIX: next_q.rdata = {16'h0000, q.exp_fix};
        default: next_q.rdata = 32'h0000_0000;
      endcase
    end
    // frame statistics and loop update
    unique case (q.state)
      ST_IDLE: begin
        if (active && pix_i.valid && pix_i.sof) begin
          next_q.state = ST_ACC;
          next_q.sum = (in_meter && in_region) ? 40'(pix_i.luma) * 40'(wgt) : 40'h0; // first pixel counts too
          next_q.cnt = (in_meter && in_region) ? 24'(wgt) : 24'h0;
        end
      end
      ST_ACC: begin
        if (pix_i.valid && in_meter && in_region) begin
          next_q.sum = q.sum + 40'(pix_i.luma) * 40'(wgt);
          next_q.cnt = q.cnt + 24'(wgt);
        end
        if (pix_i.valid && pix_i.eof) begin
          next_q.state = ST_ADJ;
        end
      end
      ST_ADJ: begin
        // average scaled to percent of full scale
        next_q.meas = (q.cnt == 24'h0) ? 8'h00 : 8'((q.sum * 40'(PCT_FULL)) / (40'(q.cnt) * 40'hff));
        next_q.state = ST_IDLE;
        next_q.armed = 1'b1;
      end
      default: next_q.state = ST_IDLE;
    endcase
    // one damped step per measured frame; armed keeps a stale measurement from stepping twice
    if (q.state == ST_IDLE && active && q.armed) begin
      next_q.armed = 1'b0;
      if (err <= TOL_PCT) begin
        next_q.settled = 1'b1;
        // once drops back to off at the target
        if (q.exp_auto == AUTO_ONCE) next_q.exp_auto = AUTO_OFF;
        if (q.gain_auto == AUTO_ONCE) next_q.gain_auto = AUTO_OFF;
      end else begin
        e_step = damp_step(q.sensor.exposure_us >> 4, q.damp) * 16'(err) + 16'h0001;
        g_step = damp_step(16'(err) * 16'h0002, q.damp) + 16'h0001;
        e_new = bright ? 17'(q.sensor.exposure_us) - 17'(e_step) : 17'(q.sensor.exposure_us) + 17'(e_step);
        g_new = bright ? 17'(q.sensor.gain_ddb) - 17'(g_step) : 17'(q.sensor.gain_ddb) + 17'(g_step);
        if (e_new[16] && bright) e_new = 17'h0;
        if (g_new[16] && bright) g_new = 17'h0;
        if (e_auto && g_auto) begin
          next_q.sensor.exposure_us = clamp16(17'(q.sensor.exposure_us), q.exp_min, q.exp_max); // narrowed limits
          next_q.sensor.gain_ddb = clamp16(17'(q.sensor.gain_ddb), q.gain_min, q.gain_max);
          if (!q.prio_exp) begin
            // gain stays at its floor until exposure is exhausted
            if (!bright && q.sensor.exposure_us >= q.exp_max) begin
              next_q.sensor.gain_ddb = clamp16(g_new, q.gain_min, q.gain_max);
            end else if (bright && q.sensor.gain_ddb > q.gain_min) begin
              next_q.sensor.gain_ddb = clamp16(g_new, q.gain_min, q.gain_max);
            end else begin
              next_q.sensor.gain_ddb = clamp16(17'h0, q.gain_min, q.gain_max);
              next_q.sensor.exposure_us = clamp16(e_new, q.exp_min, q.exp_max);
            end
          end else begin
            // exposure held short until gain is exhausted
            if (!bright && q.sensor.gain_ddb >= q.gain_max) begin
              next_q.sensor.exposure_us = clamp16(e_new, q.exp_min, q.exp_max);
            end else if (bright && q.sensor.exposure_us > q.exp_fix) begin
              next_q.sensor.exposure_us = clamp16(e_new, q.exp_fix, q.exp_max);
            end else begin
              next_q.sensor.exposure_us = clamp16(17'(q.exp_fix), q.exp_min, q.exp_max);
              next_q.sensor.gain_ddb = clamp16(g_new, q.gain_min, q.gain_max);
            end
          end
        end else if (e_auto) begin
          next_q.sensor.exposure_us = clamp16(e_new, q.exp_min, q.exp_max);
        end else begin
          next_q.sensor.gain_ddb = clamp16(g_new, q.gain_min, q.gain_max);
        end
        next_q.upd = 1'b1;
        next_q.settled = 1'b0; // still outside the band; the next frame end re-arms a step
      end
    end
  end

  // single state register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q <= '0;
      q.light <= LIGHT_NORMAL;
      q.meter <= METER_AVG;
      q.damp <= DAMP_RST;
      q.target <= TGT_RST;
      q.exp_min <= EXP_MIN_RST;
      q.exp_max <= EXP_MAX_RST;
      q.gain_min <= GAIN_MIN_RST;
      q.gain_max <= GAIN_MAX_RST;
      q.exp_fix <= EXP_FIX_RST;
      q.tgt_min <= TGT_MIN_RST;
      q.tgt_max <= TGT_MAX_RST;
      q.reg_w <= 16'(IMG_W);
      q.reg_h <= 16'(IMG_H);
      q.sensor.exposure_us <= EXP_FIX_RST;
      q.sensor.gain_ddb <= GAIN_MIN_RST;
    end else begin
      q <= next_q;
    end
  end

endmodule : aec_ctrl

// *** aec_ctrl_props.sv ***
// port checker for the exposure control block
`timescale 1ns/1ps
module aec_ctrl_props (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  input wire aec_pkg::aec_pix_s pix_i,
  input wire aec_pkg::aec_sensor_s sensor_o,
  input wire logic sensor_upd_o
);
  import aec_pkg::*;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);
  // bus side: no wait states, no error, read data shown only in the access cycle
  apb_ready_a: assert property (psel_i && penable_i |-> pready_o && !pslverr_o)
    else $error("apb access not ready");
  rdata_idle_a: assert property (!(psel_i && penable_i) |-> prdata_o == 32'h0)
    else $error("read data outside access");
  unmapped_read_a: assert property (psel_i && penable_i && !pwrite_i && paddr_i > OFF_EXP_FIX |-> prdata_o == 32'h0)
    else $error("unmapped read not zero");
  // sensor side: reset setting, pulse shape and cause
  reset_setting_a: assert property ($rose(nrst_i) |-> sensor_o == {EXP_FIX_RST, 16'h0000})
    else $error("sensor reset value wrong");
  upd_pulse_a: assert property (sensor_upd_o |=> !sensor_upd_o [*3])
    else $error("update pulse too long");
  upd_cause_a: assert property (sensor_upd_o |-> $past(pix_i.valid && pix_i.eof, 3))
    else $error("update without frame end");
  quiet_hold_a: assert property (!sensor_upd_o |-> $stable(sensor_o))
    else $error("sensor moved without update");
  // the bench never widens the limits past their reset values
  gain_cap_a: assert property (sensor_o.gain_ddb <= GAIN_MAX_RST)
    else $error("gain above limit");
  exp_floor_a: assert property (sensor_o.exposure_us >= EXP_MIN_RST)
    else $error("exposure below limit");
endmodule : aec_ctrl_props

// *** aec_sensor_model.sv ***
// sensor stand-in: sends frames whose brightness follows exposure and gain
`timescale 1ns/1ps
module aec_sensor_model #(
  parameter int W = 24,
  parameter int H = 24
) (
  input wire logic clk_i,
  input wire aec_pkg::aec_sensor_s sensor_i,
  input wire logic [7:0] edge_lvl_i,
  input wire logic [7:0] mid_lvl_i,
  output aec_pkg::aec_pix_s pix_o
);
  import aec_pkg::*;
  // stream idle until the bench asks for a frame
  initial pix_o = '0;
  // 5x5 centre block lit by mid level; gain scaled linearly, good enough for a loop test
  task automatic frame();
    int v;
    for (int y = 0; y < H; y++) begin
      for (int x = 0; x < W; x++) begin
        v = (x >= W/2-2 && x <= W/2+2 && y >= H/2-2 && y <= H/2+2) ? mid_lvl_i : edge_lvl_i;
        v = v * sensor_i.exposure_us / EXP_FIX_RST;
        v = (v > 255 ? 255 : v) * (60 + sensor_i.gain_ddb) / 60;
        @(posedge clk_i);
        pix_o <= {1'b1, 1'(x == 0 && y == 0), 1'(x == W-1 && y == H-1), 16'(x), 16'(y), 8'(v > 255 ? 255 : v)};
      end
    end
    // released lines show inverted junk so stale data cannot pass
    @(posedge clk_i);
    pix_o <= {1'b0, ~pix_o[41:0]};
    repeat (6) @(posedge clk_i);
  endtask : frame
endmodule : aec_sensor_model

// *** aec_ctrl_test.sv ***
// self-checking bench for the exposure control block
`timescale 1ns/1ps
module aec_ctrl_test;
  import aec_pkg::*;
  localparam int SZ = 24;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [7:0] edge_lvl = 8'h14;
  logic [7:0] mid_lvl = 8'hc8;
  logic [31:0] pwdata_i = 32'h0;
  logic [31:0] prdata_o, q;
  logic pready_o, pslverr_o, sensor_upd_o;
  aec_pix_s pix_i;
  aec_sensor_s sensor_o;
  int err_count = 0;
  int checked = 0;
  int cyc = 0;
  aec_ctrl #(.IMG_W(SZ), .IMG_H(SZ)) aec_ctrl_i (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
    .pready_o(pready_o), .pslverr_o(pslverr_o), .pix_i(pix_i), .sensor_o(sensor_o), .sensor_upd_o(sensor_upd_o));
  aec_sensor_model #(.W(SZ), .H(SZ)) aec_sensor_model_i (.clk_i(clk_i), .sensor_i(sensor_o),
    .edge_lvl_i(edge_lvl), .mid_lvl_i(mid_lvl), .pix_o(pix_i));
  // 20 MHz clock
  initial forever #25 clk_i = ~clk_i;
  // hang guard, well above the longest frame loops
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      err_count++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // one apb transfer; the leading edge keeps back-to-back calls from double driving
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
    end while (pready_o !== 1'b1); // the slave sets the pace; only the hang guard ends a stuck transfer
    q = prdata_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  function automatic logic [31:0] ctl(input logic [1:0] ea, ga, input logic tu, pr, input logic [1:0] li, me);
    return 32'({DAMP_RST, 2'b00, me, li, pr, tu, ga, ea});
  endfunction : ctl
  // frames until the loop reports settled, bounded
  task automatic settle();
    for (int i = 0; i < 16; i++) begin
      aec_sensor_model_i.frame();
      apb(0, OFF_STATUS, 0);
      if (q[24] === 1'b1) break;
    end
  endtask : settle
  task automatic t_regs();
    logic [7:0] a[7] = '{OFF_CTRL, OFF_TARGET, OFF_EXP_LIM, OFF_GAIN_LIM, OFF_TGT_LIM, OFF_EXP_FIX, 8'h24};
    logic [31:0] e[7] = '{{16'h0, DAMP_RST, 12'h0}, {24'h0, TGT_RST}, {EXP_MAX_RST, EXP_MIN_RST},
      {GAIN_MAX_RST, GAIN_MIN_RST}, {16'h0, TGT_MAX_RST, TGT_MIN_RST}, {16'h0, EXP_FIX_RST}, 32'h0};
    apb(1, 8'h24, 32'hffff_ffff);
    for (int i = 0; i < 7; i++) begin
      apb(0, a[i], 0);
      chk("reset_reg", e[i], q);
    end
    $display("test regs done");
  endtask : t_regs
  // exposure pinned so only the metering choice moves the measurement
  task automatic t_meter();
    logic [7:0] mv[3];
    apb(1, OFF_EXP_LIM, {EXP_FIX_RST, EXP_FIX_RST});
    for (int m = 0; m < 3; m++) begin
      apb(1, OFF_CTRL, ctl(AUTO_CONT, AUTO_OFF, 1, 0, LIGHT_NORMAL, 2'(m)));
      aec_sensor_model_i.frame();
      apb(0, OFF_STATUS, 0);
      mv[m] = q[15:8];
    end
    chk("spot_over_part", 1, mv[1] > mv[2]);
    chk("part_over_avg", 1, mv[2] > mv[0]);
    apb(1, OFF_CTRL, ctl(AUTO_CONT, AUTO_OFF, 1, 0, LIGHT_BACK, METER_SPOT));
    apb(0, OFF_CTRL, 0);
    chk("meter_locked", {METER_PART, LIGHT_BACK}, q[9:6]);
    apb(1, OFF_CTRL, ctl(AUTO_CONT, AUTO_OFF, 1, 0, LIGHT_NORMAL, METER_AVG) | 32'h0c00);
    apb(1, OFF_REGION_OFS, {16'h000a, 16'h000a});
    apb(1, OFF_REGION_SIZE, {16'h0004, 16'h0004});
    aec_sensor_model_i.frame();
    apb(0, OFF_STATUS, 0);
    chk("region_meas", 1, q[15:8] inside {[8'h4b:8'h50]});
    $display("test meter done");
  endtask : t_meter
  task automatic t_target();
    logic [7:0] tg[3] = '{8'h32, 8'h32, 8'h5a};
    logic [4:0] bi[3] = '{5'h03, 5'h1d, 5'h00};
    logic [7:0] tm[3] = '{8'h64, 8'h64, 8'h50};
    logic [7:0] ex[3] = '{8'h3e, 8'h26, 8'h50};
    logic [7:0] ev[3];
    for (int i = 0; i < 3; i++) begin
      apb(1, OFF_TGT_LIM, {16'h0, tm[i], 8'h00});
      apb(1, OFF_TARGET, {24'h0, tg[i]});
      apb(1, OFF_CTRL, ctl(AUTO_CONT, AUTO_OFF, 1, 0, LIGHT_NORMAL, METER_AVG) | 32'(bi[i]) << CTRL_BIAS_LSB);
      aec_sensor_model_i.frame();
      apb(0, OFF_STATUS, 0);
      chk("eff_target", ex[i], q[23:16]);
    end
    apb(1, OFF_CTRL, ctl(AUTO_CONT, AUTO_OFF, 1, 0, LIGHT_NORMAL, METER_AVG) | 32'h000a_0000);
    apb(0, OFF_CTRL, 0);
    chk("bias_kept", 5'h00, q[20:16]);
    apb(1, OFF_TGT_LIM, {16'h0, TGT_MAX_RST, TGT_MIN_RST});
    for (int l = 0; l < 3; l++) begin
      apb(1, OFF_CTRL, ctl(AUTO_CONT, AUTO_OFF, 0, 0, 2'(l), METER_AVG));
      aec_sensor_model_i.frame();
      apb(0, OFF_STATUS, 0);
      ev[l] = q[23:16];
    end
    chk("normal_tgt", TGT_RST, ev[0]);
    chk("back_shift", TGT_RST + LIGHT_SHIFT, ev[1]);
    chk("front_shift", TGT_RST - LIGHT_SHIFT, ev[2]);
    $display("test target done");
  endtask : t_target
  // uniform dim scene: exposure alone, then both under each priority
  task automatic t_loop();
    edge_lvl <= 8'h28;
    mid_lvl <= 8'h28;
    apb(1, OFF_EXP_LIM, {EXP_MAX_RST, EXP_MIN_RST});
    apb(1, OFF_TARGET, 32'h32);
    apb(1, OFF_CTRL, ctl(AUTO_CONT, AUTO_OFF, 1, 0, LIGHT_NORMAL, METER_AVG));
    settle();
    chk("cont_meas", 1, q[15:8] inside {[8'h30:8'h34]});
    chk("cont_gain", 16'h0, sensor_o.gain_ddb);
    // dimmer scene so the loop leaves its settled point under the narrower limits
    edge_lvl <= 8'h14;
    mid_lvl <= 8'h14;
    apb(1, OFF_EXP_LIM, {16'h1f40, EXP_MIN_RST});
    apb(1, OFF_GAIN_LIM, {16'h0064, 16'h0000});
    apb(1, OFF_CTRL, ctl(AUTO_CONT, AUTO_CONT, 1, 0, LIGHT_NORMAL, METER_AVG));
    settle();
    chk("gp_exp", 16'h1f40, sensor_o.exposure_us);
    chk("gp_gain", 1, sensor_o.gain_ddb > 0 && sensor_o.gain_ddb <= 16'h0064);
    apb(1, OFF_GAIN_LIM, {GAIN_MAX_RST, GAIN_MIN_RST});
    apb(1, OFF_CTRL, ctl(AUTO_CONT, AUTO_CONT, 1, 1, LIGHT_NORMAL, METER_AVG));
    settle();
    chk("ep_exp", EXP_FIX_RST, sensor_o.exposure_us);
    chk("ep_gain", 1, sensor_o.gain_ddb > 0);
    $display("test loop done");
  endtask : t_loop
  task automatic t_once();
    aec_sensor_s s0;
    apb(1, OFF_TARGET, 32'h28);
    apb(1, OFF_CTRL, ctl(AUTO_ONCE, AUTO_OFF, 1, 0, LIGHT_NORMAL, METER_AVG));
    for (int i = 0; i < 16; i++) begin
      aec_sensor_model_i.frame();
      apb(0, OFF_CTRL, 0);
      if (q[1:0] === AUTO_OFF) break;
    end
    chk("once_off", AUTO_OFF, q[1:0]);
    s0 = sensor_o;
    aec_sensor_model_i.frame();
    chk("off_hold", s0, sensor_o);
    $display("test once done");
  endtask : t_once
  // reset, then the scenarios in turn
  initial begin
    repeat (6) @(posedge clk_i);
    nrst_i <= 1'b1;
    t_regs();
    t_meter();
    t_target();
    t_loop();
    t_once();
    complete_run();
  end
endmodule : aec_ctrl_test
bind aec_ctrl aec_ctrl_props aec_ctrl_props_i (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
  .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .pix_i(pix_i), .sensor_o(sensor_o), .sensor_upd_o(sensor_upd_o));
